// ==== verilog/rpas_map.svh ====
// register map, field positions, mode codes and reset values of the playback sequencer
`ifndef RPAS_MAP_SVH
`define RPAS_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RPAS_OFS_SEG0_ADDR 8'h00
`define RPAS_OFS_SEG0_CFG 8'h04
`define RPAS_OFS_SEG1_ADDR 8'h08
`define RPAS_OFS_SEG1_CFG 8'h0C
`define RPAS_OFS_CTRL 8'h10
`define RPAS_OFS_STATUS 8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RPAS_START_LSB 0
`define RPAS_END_LSB 16
`define RPAS_RATE_LSB 0
`define RPAS_MODE_LSB 16
`define RPAS_DEST_BIT 0
`define RPAS_CCI_LSB 8
`define RPAS_ST_SEL_BIT 12
`define RPAS_ST_RUN_BIT 13
`define RPAS_ST_DOWN_BIT 14
`define RPAS_ST_ZERO_BIT 15

// ----------------------------------------------------------------
// playback mode codes and reset values
// ----------------------------------------------------------------
`define RPAS_MODE_RAMP 3'h1
`define RPAS_MODE_BIDIR 3'h2
`define RPAS_MODE_CBIDIR 3'h3
`define RPAS_MODE_RECIRC 3'h4
`define RPAS_SEG_ADDR_RST 32'h00000000
`define RPAS_SEG_CFG_RST 32'h00000001
`define RPAS_CTRL_RST 32'h00000100

`endif

// ==== verilog/rpas_pkg.sv ====
// types shared by the playback sequencer
package rpas_pkg;
	typedef enum logic [1:0] {RPAS_IDLE, RPAS_ARMED, RPAS_RUN, RPAS_HALT} rpas_state_t;
	typedef logic [2:0] rpas_mode_t;
endpackage : rpas_pkg

// ==== verilog/rpas_sequencer.sv ====
// playback address sequencer: register port, trigger edges, step timer and address state machine
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "rpas_map.svh"
module rpas_sequencer import rpas_pkg::*; #(
	parameter int ADDR_W = 10,
	parameter int RATE_W = 16,
	parameter int CCI_W = 6
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// update strobe and trigger pin
	input wire logic io_update_i,
	input wire logic ram_trigger_pin_i,
	// playback side
	output logic [ADDR_W-1:0] ram_addr_o,
	output logic sample_stb_o,
	output logic play_active_o,
	output logic dest_mult_o,
	output logic mult_zero_o
);
	localparam int TMR_W = RATE_W + CCI_W + 2;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// status packs the address below the flag bits at 12..15
	if (ADDR_W < 2 || ADDR_W > 12) begin : g_bad_addr
		$error("ADDR_W must lie in 2..12");
	end
	if (RATE_W < 1 || RATE_W > 16) begin : g_bad_rate
		$error("RATE_W must lie in 1..16");
	end
	if (CCI_W < 1 || CCI_W > 8) begin : g_bad_cci
		$error("CCI_W must lie in 1..8");
	end

	// step interval in clocks; baseband path steps every clock
	function automatic logic [TMR_W-1:0] rpas_period(input logic dest, input logic [CCI_W-1:0] r,
		input logic [RATE_W-1:0] m);
		logic [TMR_W-1:0] p;
		p = TMR_W'({r, 2'b00}) * TMR_W'(m);
		if (!dest || p == '0) begin
			p = TMR_W'(1);
		end
		return p;
	endfunction : rpas_period

	// mode field decode of a config word
	function automatic rpas_mode_t rpas_mode_of(input logic [31:0] cfg);
		return cfg[`RPAS_MODE_LSB +: 3];
	endfunction : rpas_mode_of

	function automatic logic rpas_valid(input rpas_mode_t m);
		return (m == `RPAS_MODE_RAMP) || (m == `RPAS_MODE_BIDIR) ||
			(m == `RPAS_MODE_CBIDIR) || (m == `RPAS_MODE_RECIRC);
	endfunction : rpas_valid

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [31:0] seg_addr_sh [2];
	logic [31:0] seg_cfg_sh [2];
	logic [31:0] ctrl_sh;
	logic [31:0] seg_addr_act [2];
	logic [31:0] seg_cfg_act [2];
	logic [31:0] ctrl_act;
	rpas_state_t state;
	logic seg_sel;
	logic dir_down;
	logic [TMR_W-1:0] tmr_cnt;

	// software writes land in shadow copies
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			seg_addr_sh[0] <= `RPAS_SEG_ADDR_RST;
			seg_addr_sh[1] <= `RPAS_SEG_ADDR_RST;
			seg_cfg_sh[0] <= `RPAS_SEG_CFG_RST;
			seg_cfg_sh[1] <= `RPAS_SEG_CFG_RST;
			ctrl_sh <= `RPAS_CTRL_RST;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`RPAS_OFS_SEG0_ADDR: seg_addr_sh[0] <= reg_wdata_i;
				`RPAS_OFS_SEG0_CFG: seg_cfg_sh[0] <= reg_wdata_i;
				`RPAS_OFS_SEG1_ADDR: seg_addr_sh[1] <= reg_wdata_i;
				`RPAS_OFS_SEG1_CFG: seg_cfg_sh[1] <= reg_wdata_i;
				`RPAS_OFS_CTRL: ctrl_sh <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// the update strobe commits shadows, so a half-written descriptor never plays
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			seg_addr_act[0] <= `RPAS_SEG_ADDR_RST;
			seg_addr_act[1] <= `RPAS_SEG_ADDR_RST;
			seg_cfg_act[0] <= `RPAS_SEG_CFG_RST;
			seg_cfg_act[1] <= `RPAS_SEG_CFG_RST;
			ctrl_act <= `RPAS_CTRL_RST;
		end else if (io_update_i) begin
			seg_addr_act <= seg_addr_sh;
			seg_cfg_act <= seg_cfg_sh;
			ctrl_act <= ctrl_sh;
		end
	end

	// read data one cycle after the strobe, unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`RPAS_OFS_SEG0_ADDR: reg_rdata_o <= seg_addr_sh[0];
				`RPAS_OFS_SEG0_CFG: reg_rdata_o <= seg_cfg_sh[0];
				`RPAS_OFS_SEG1_ADDR: reg_rdata_o <= seg_addr_sh[1];
				`RPAS_OFS_SEG1_CFG: reg_rdata_o <= seg_cfg_sh[1];
				`RPAS_OFS_CTRL: reg_rdata_o <= ctrl_sh;
				`RPAS_OFS_STATUS: begin
					reg_rdata_o <= 32'(ram_addr_o);
					reg_rdata_o[`RPAS_ST_SEL_BIT] <= seg_sel;
					reg_rdata_o[`RPAS_ST_RUN_BIT] <= play_active_o;
					reg_rdata_o[`RPAS_ST_DOWN_BIT] <= dir_down;
					reg_rdata_o[`RPAS_ST_ZERO_BIT] <= mult_zero_o;
				end
				default: reg_rdata_o <= 32'h00000000;
			endcase
		end else begin
			reg_rdata_o <= 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// trigger synchroniser and edge detect
	// ----------------------------------------------------------------
	logic trig_s1;
	logic trig_s2;
	logic trig_s3;
	logic trig_rise;
	logic trig_fall;

	// edge detect looks only at the second and third stages
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_s3 <= 1'b0;
		end else begin
			trig_s1 <= ram_trigger_pin_i;
			trig_s2 <= trig_s1;
			trig_s3 <= trig_s2;
		end
	end
	assign trig_rise = trig_s2 & ~trig_s3;
	assign trig_fall = ~trig_s2 & trig_s3;

	// ----------------------------------------------------------------
	// start decode
	// ----------------------------------------------------------------
	logic start_evt;
	logic tgt_sel;
	rpas_mode_t tgt_mode;
	logic [ADDR_W-1:0] tgt_start;
	logic [ADDR_W-1:0] tgt_end;
	rpas_mode_t cur_mode;
	logic [ADDR_W-1:0] cur_start;
	logic [ADDR_W-1:0] cur_end;
	logic [TMR_W-1:0] period;
	logic tick;

	// on an update the fresh shadow values decide, since actives load this same edge
	always_comb begin
		start_evt = io_update_i | trig_rise | trig_fall;
		if (trig_rise) begin
			tgt_sel = 1'b0;
		end else if (trig_fall) begin
			tgt_sel = 1'b1;
		end else if (io_update_i && rpas_mode_of(seg_cfg_sh[0]) == `RPAS_MODE_BIDIR) begin
			tgt_sel = 1'b0;
		end else begin
			tgt_sel = seg_sel;
		end
		if (io_update_i) begin
			tgt_mode = rpas_mode_of(seg_cfg_sh[tgt_sel]);
			tgt_start = seg_addr_sh[tgt_sel][`RPAS_START_LSB +: ADDR_W];
			tgt_end = seg_addr_sh[tgt_sel][`RPAS_END_LSB +: ADDR_W];
		end else begin
			tgt_mode = rpas_mode_of(seg_cfg_act[tgt_sel]);
			tgt_start = seg_addr_act[tgt_sel][`RPAS_START_LSB +: ADDR_W];
			tgt_end = seg_addr_act[tgt_sel][`RPAS_END_LSB +: ADDR_W];
		end
		cur_mode = rpas_mode_of(seg_cfg_act[seg_sel]);
		cur_start = seg_addr_act[seg_sel][`RPAS_START_LSB +: ADDR_W];
		cur_end = seg_addr_act[seg_sel][`RPAS_END_LSB +: ADDR_W];
		period = rpas_period(ctrl_act[`RPAS_DEST_BIT], ctrl_act[`RPAS_CCI_LSB +: CCI_W],
			seg_cfg_act[seg_sel][`RPAS_RATE_LSB +: RATE_W]);
	end

	// ----------------------------------------------------------------
	// step timer
	// ----------------------------------------------------------------
	assign tick = (state == RPAS_RUN) && (tmr_cnt == period - TMR_W'(1));

	// a start event restarts the interval so the first step is a full one
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || start_evt || tick || state != RPAS_RUN) begin
			tmr_cnt <= '0;
		end else begin
			tmr_cnt <= tmr_cnt + TMR_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// address state machine
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= RPAS_IDLE;
			seg_sel <= 1'b0;
			dir_down <= 1'b0;
			ram_addr_o <= '0;
			sample_stb_o <= 1'b0;
		end else if (start_evt) begin
			seg_sel <= tgt_sel;
			sample_stb_o <= 1'b0;
			if (!rpas_valid(tgt_mode)) begin
				state <= RPAS_IDLE;
			end else if (tgt_mode == `RPAS_MODE_BIDIR && trig_fall) begin
				state <= RPAS_RUN;
				dir_down <= 1'b1;
				ram_addr_o <= tgt_end;
				sample_stb_o <= 1'b1;
			end else if (tgt_mode == `RPAS_MODE_BIDIR && !trig_rise) begin
				state <= RPAS_ARMED;
			end else begin
				state <= RPAS_RUN;
				dir_down <= 1'b0;
				ram_addr_o <= tgt_start;
				sample_stb_o <= 1'b1;
			end
		end else if (tick) begin
			sample_stb_o <= 1'b1;
			case (cur_mode)
				`RPAS_MODE_RAMP, `RPAS_MODE_BIDIR: begin
					if (!dir_down && ram_addr_o == cur_end) begin
						state <= RPAS_HALT;
						sample_stb_o <= 1'b0;
					end else if (dir_down && ram_addr_o == cur_start) begin
						state <= RPAS_HALT;
						sample_stb_o <= 1'b0;
					end else if (dir_down) begin
						ram_addr_o <= ram_addr_o - ADDR_W'(1);
					end else begin
						ram_addr_o <= ram_addr_o + ADDR_W'(1);
					end
				end
				`RPAS_MODE_CBIDIR: begin
					if (!dir_down && ram_addr_o == cur_end) begin
						dir_down <= 1'b1;
						ram_addr_o <= ram_addr_o - ADDR_W'(1);
					end else if (dir_down && ram_addr_o == cur_start) begin
						dir_down <= 1'b0;
						ram_addr_o <= ram_addr_o + ADDR_W'(1);
					end else if (dir_down) begin
						ram_addr_o <= ram_addr_o - ADDR_W'(1);
					end else begin
						ram_addr_o <= ram_addr_o + ADDR_W'(1);
					end
				end
				`RPAS_MODE_RECIRC: begin
					if (ram_addr_o == cur_end) begin
						ram_addr_o <= cur_start;
					end else begin
						ram_addr_o <= ram_addr_o + ADDR_W'(1);
					end
				end
				default: begin
					state <= RPAS_IDLE;
					sample_stb_o <= 1'b0;
				end
			endcase
		end else begin
			sample_stb_o <= 1'b0;
		end
	end

	// with the multiplier destination set, multipliers see zero from an update until the next trigger change
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mult_zero_o <= 1'b0;
		end else if (trig_rise || trig_fall) begin
			mult_zero_o <= 1'b0;
		end else if (io_update_i) begin
			mult_zero_o <= ctrl_sh[`RPAS_DEST_BIT];
		end
	end

	assign play_active_o = (state == RPAS_RUN);
	assign dest_mult_o = ctrl_act[`RPAS_DEST_BIT];

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_rise_selects_seg0: assert property (trig_rise |=> !seg_sel)
		else $error("rising trigger did not select descriptor 0");
	a_fall_selects_seg1: assert property (trig_fall |=> seg_sel)
		else $error("falling trigger did not select descriptor 1");
	a_trig_sync_lag: assert property (trig_rise |-> $past(ram_trigger_pin_i, 2) && !$past(ram_trigger_pin_i, 3))
		else $error("trigger edge not two stages behind pin");
	a_addr_single_step: assert property ((tick && !start_evt && cur_mode != `RPAS_MODE_RECIRC && state == RPAS_RUN)
		|=> (ram_addr_o == $past(ram_addr_o) + ADDR_W'(1)) || (ram_addr_o == $past(ram_addr_o) - ADDR_W'(1))
		|| (ram_addr_o == $past(ram_addr_o)))
		else $error("address moved by more than one");
	a_addr_waits_timer: assert property ((!tick && !start_evt) |=> $stable(ram_addr_o))
		else $error("address moved without timer expiry");
	a_ramp_halts: assert property ((tick && !start_evt && cur_mode == `RPAS_MODE_RAMP && ram_addr_o == cur_end)
		|=> state == RPAS_HALT ##1 ($past(start_evt) || (state == RPAS_HALT && $stable(ram_addr_o))))
		else $error("ramp-up did not halt at end address");
	a_bidir_arms: assert property ((io_update_i && !trig_rise && !trig_fall
		&& rpas_mode_of(seg_cfg_sh[0]) == `RPAS_MODE_BIDIR) |=> state == RPAS_ARMED && !seg_sel
		&& $stable(ram_addr_o))
		else $error("bidirectional update did not just arm");
	a_bidir_fall_load: assert property ((trig_fall && tgt_mode == `RPAS_MODE_BIDIR)
		|=> dir_down && ram_addr_o == $past(tgt_end) && tmr_cnt == '0)
		else $error("falling edge did not load end address downward");
	a_cbidir_turn: assert property ((tick && !start_evt && cur_mode == `RPAS_MODE_CBIDIR && !dir_down
		&& ram_addr_o == cur_end) |=> dir_down && state == RPAS_RUN)
		else $error("continuous ramp did not reverse at end");
	a_recirc_wrap: assert property ((tick && !start_evt && cur_mode == `RPAS_MODE_RECIRC && ram_addr_o == cur_end)
		|=> ram_addr_o == $past(cur_start) && state == RPAS_RUN)
		else $error("recirculate did not reload start address");
	a_invalid_idle: assert property ((start_evt && !rpas_valid(tgt_mode))
		|=> state == RPAS_IDLE && $stable(ram_addr_o))
		else $error("invalid mode did not leave sequencer idle");
endmodule : rpas_sequencer

// ==== dv/rpas_sink_model.sv ====
// far-side model: waveform memory image and sample consumer of the playback sequencer
`timescale 1ns/1ps
module rpas_sink_model #(
	parameter int SEG1_LO = 50,
	parameter int SEG1_HI = 54
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// playback side
	input wire logic [9:0] addr_i,
	input wire logic stb_i,
	output logic [31:0] sample_o
);
	logic [9:0] q[$];
	int stamp[$];
	int cyc;
	logic [31:0] image [0:1023];

	// image: descriptor 1 region stored back to front, it is read downward
	initial begin
		cyc = 0;
		for (int i = 0; i < 1024; i++) begin
			image[i] = 32'(i);
		end
		for (int i = SEG1_LO; i <= SEG1_HI; i++) begin
			image[i] = 32'(SEG1_LO + SEG1_HI - i);
		end
	end

	// every strobe delivers one sample; address and cycle are logged for the bench
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (!rst_n_i) begin
			sample_o <= 32'h00000000;
		end else if (stb_i === 1'b1) begin
			q.push_back(addr_i);
			stamp.push_back(cyc);
			sample_o <= image[addr_i];
		end
	end

	// forget what was seen so far
	task flush();
		q.delete();
		stamp.delete();
	endtask : flush
endmodule : rpas_sink_model

// ==== dv/tb_top.sv ====
// self-checking bench of the playback address sequencer
`timescale 1ns/1ps
`include "rpas_map.svh"
module tb_top;
	logic clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, io_update_i = 1'b0, ram_trigger_pin_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h00000000, reg_rdata_o, rd, sample;
	logic [9:0] ram_addr_o, held;
	logic sample_stb_o, play_active_o, dest_mult_o, mult_zero_o;
	int miscompares = 0, cmp_count = 0, ticks = 0;

	always #25 clk_i = ~clk_i;

	rpas_sequencer dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .io_update_i(io_update_i),
		.ram_trigger_pin_i(ram_trigger_pin_i), .ram_addr_o(ram_addr_o), .sample_stb_o(sample_stb_o),
		.play_active_o(play_active_o), .dest_mult_o(dest_mult_o), .mult_zero_o(mult_zero_o));
	rpas_sink_model sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(ram_addr_o), .stb_i(sample_stb_o),
		.sample_o(sample));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc
	task reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : reg_wr
	// read data stand only in the cycle after the read strobe
	task reg_rd(input logic [7:0] a);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		rd = reg_rdata_o;
	endtask : reg_rd
	task seg(input int s, input int e, input logic [2:0] m, input logic [15:0] r);
		reg_wr(`RPAS_OFS_SEG0_ADDR, {6'h00, 10'(e), 6'h00, 10'(s)});
		reg_wr(`RPAS_OFS_SEG0_CFG, {13'h0000, m, r});
		reg_wr(`RPAS_OFS_SEG1_ADDR, {6'h00, 10'(e + 18), 6'h00, 10'(s + 18)});
		reg_wr(`RPAS_OFS_SEG1_CFG, {13'h0000, m, r});
	endtask : seg
	task update();
		@(posedge clk_i);
		io_update_i <= 1'b1;
		@(posedge clk_i);
		io_update_i <= 1'b0;
	endtask : update
	// the pin change acts three edges later; entries logged before that are stale
	task pin(input logic v);
		@(posedge clk_i);
		ram_trigger_pin_i <= v;
		repeat (3) @(posedge clk_i);
		#1;
		sink.flush();
	endtask : pin
	// logged addresses against a list; exact length unless only the head matters
	task chk_seq(input int e[$], input bit exact);
		if (exact) chk(sink.q.size(), e.size());
		else chk(sink.q.size() >= e.size(), 1);
		for (int i = 0; i < e.size() && i < sink.q.size(); i++) chk(sink.q[i], e[i]);
	endtask : chk_seq

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_regs();
		reg_rd(`RPAS_OFS_SEG0_CFG); chk(rd, `RPAS_SEG_CFG_RST);
		reg_rd(`RPAS_OFS_CTRL); chk(rd, `RPAS_CTRL_RST);
		reg_rd(`RPAS_OFS_SEG1_ADDR); chk(rd, `RPAS_SEG_ADDR_RST);
		reg_wr(8'h18, 32'hFFFFFFFF);
		reg_rd(8'h18); chk(rd, 32'h00000000);
		$display("test regs done");
	endtask : t_regs
	task t_ramp();
		seg(2, 5, `RPAS_MODE_RAMP, 16'h0001);
		sink.flush();
		update();
		cyc(12);
		chk_seq('{2, 3, 4, 5}, 1);
		chk(play_active_o, 1'b0);
		chk(ram_addr_o, 10'h005);
		$display("test ramp done");
	endtask : t_ramp
	task t_bidir();
		reg_wr(`RPAS_OFS_SEG0_ADDR, {6'h00, 10'd20, 6'h00, 10'd2});
		reg_wr(`RPAS_OFS_SEG1_ADDR, {6'h00, 10'd54, 6'h00, 10'd50});
		reg_wr(`RPAS_OFS_SEG0_CFG, {13'h0000, `RPAS_MODE_BIDIR, 16'h0001});
		reg_wr(`RPAS_OFS_SEG1_CFG, {13'h0000, `RPAS_MODE_BIDIR, 16'h0001});
		update();
		cyc(8);
		chk(play_active_o, 1'b0);
		pin(1'b1);
		cyc(28);
		chk(sink.q.size(), 19);
		chk(sink.q[0], 2);
		chk(ram_addr_o, 10'd20);
		pin(1'b0);
		cyc(12);
		chk_seq('{54, 53, 52, 51, 50}, 1);
		chk(sample, 32'd54);
		reg_rd(`RPAS_OFS_STATUS);
		chk(rd, 32'(50) | (32'h1 << `RPAS_ST_SEL_BIT) | (32'h1 << `RPAS_ST_DOWN_BIT));
		pin(1'b1);
		cyc(5);
		chk(play_active_o, 1'b1);
		pin(1'b0);
		cyc(4);
		chk_seq('{54, 53, 52, 51}, 1);
		chk(ram_addr_o, 10'd50);
		$display("test bidir done");
	endtask : t_bidir
	task t_cbidir();
		seg(4, 6, `RPAS_MODE_CBIDIR, 16'h0001);
		sink.flush();
		update();
		cyc(9);
		chk_seq('{22, 23, 24, 23, 22, 23, 24}, 0);
		pin(1'b1);
		cyc(9);
		chk_seq('{4, 5, 6, 5, 4}, 0);
		$display("test cbidir done");
	endtask : t_cbidir
	task t_recirc();
		seg(4, 6, `RPAS_MODE_RECIRC, 16'h0001);
		sink.flush();
		update();
		cyc(9);
		chk_seq('{4, 5, 6, 4, 5, 6, 4}, 0);
		pin(1'b0);
		cyc(9);
		chk_seq('{22, 23, 24, 22, 23}, 0);
		$display("test recirc done");
	endtask : t_recirc
	task t_invalid();
		seg(4, 6, 3'h5, 16'h0001);
		update();
		cyc(2);
		held = ram_addr_o;
		sink.flush();
		cyc(10);
		chk(sink.q.size(), 0);
		chk(ram_addr_o, held);
		chk(play_active_o, 1'b0);
		$display("test invalid done");
	endtask : t_invalid
	// multipliers as destination: ramp-up only, continuous modes kept away
	task t_mult();
		reg_wr(`RPAS_OFS_CTRL, 32'h00000201);
		seg(0, 9, `RPAS_MODE_RAMP, 16'h0003);
		update();
		#1;
		chk(mult_zero_o, 1'b1);
		chk(dest_mult_o, 1'b1);
		pin(1'b1);
		cyc(60);
		chk(mult_zero_o, 1'b0);
		chk(sink.q.size() > 1, 1);
		chk(sink.q[0], 0);
		chk(sink.stamp[1] - sink.stamp[0], 24);
		$display("test mult done");
	endtask : t_mult

	// ----------------------------------------------------------------
	// verdict
	// ----------------------------------------------------------------
	task final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : final_report

	// hang guard well beyond the whole sequence
	always @(posedge clk_i) begin
		ticks++;
		if (ticks == 4000) begin
			miscompares++;
			final_report();
		end
	end

	initial begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_regs();
		t_ramp();
		t_bidir();
		t_cbidir();
		t_recirc();
		t_invalid();
		t_mult();
		final_report();
	end
endmodule : tb_top
